// ### apb_host.sv
`timescale 1ns/10ps

module apb_host (
  input  wire logic        clk,
  output logic [11:0]      paddr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata
);
  initial begin
    paddr = 12'h000;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
  end

  // One APB transfer: setup cycle, then access phase waiting up to 16 cycles for pready
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] rd, output logic er,
                      output logic hung);
    int n;
    hung = 1'b1;
    rd = 32'h0000_0000;
    er = 1'b0;
    @(posedge clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    pstrb <= s;
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clk);
      if (pready === 1'b1) begin
        rd = prdata;
        er = pslverr;
        hung = 1'b0;
        break;
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
    // Released data lines must not keep looking valid
    pwdata <= ~d;
  endtask
endmodule

// ### nfc_framing_option_registers.sv
`timescale 1ns/10ps
`include "nfc_opt_defs.svh"

module nfc_framing_option_registers (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  input  wire logic        set_default_cmd,
  input  wire logic        analog_preset_cmd,
  input  wire logic        preset_am,
  input  wire logic        preset_field_det,
  input  wire logic        tx_reqa_cmd,
  input  wire logic        tx_wupa_cmd,
  input  wire logic        anticollision_frame,
  input  wire logic        bpsk_mode,
  input  wire logic [1:0]  bit_rate,
  output logic [7:0]       reply_delay,
  output logic             reply_delay_valid,
  output logic             accept_no_sof,
  output logic             accept_no_eof,
  output logic             eof_up_to_12,
  output logic             phase_tolerant,
  output logic [6:0]       preamble_len,
  output logic [3:0]       report_pulses,
  output logic             pulses_valid,
  output logic [2:0]       subcarrier_div_log2,
  output logic             subcarrier_valid,
  output logic [2:0]       tx_period_div_log2,
  output logic             tx_period_valid,
  output logic             skip_crc,
  output logic             crc_to_fifo,
  output logic             amplitude_mode,
  output logic             field_detector_on,
  output logic             driver_float,
  output logic             rx_tolerant,
  output logic [1:0]       field_on_count
);

  nfc_opt_pkg::state_type state;
  nfc_opt_pkg::state_type next_state;

  logic       access;
  logic       wr;
  logic       hit_rx;
  logic       hit_stream;
  logic       hit_aux;
  logic       hit_status;
  logic [7:0] rx_v;
  logic [7:0] sm_v;
  logic [7:0] ax_v;

  assign access     = psel && penable && !state.pready;
  assign wr         = access && pwrite && pstrb[0];
  assign hit_rx     = paddr == `ADDR_TYPEB_TYPEF_RX_OPTIONS;
  assign hit_stream = paddr == `ADDR_STREAM_MODE_DEFINITION;
  assign hit_aux    = paddr == `ADDR_AUXILIARY_OPTIONS;
  assign hit_status = paddr == `ADDR_EVENT_STATUS;

  always_comb begin
    next_state = state;
    next_state.pready  = access;
    next_state.pslverr = access && !(hit_rx || hit_stream || hit_aux || hit_status);
    next_state.prdata  = 32'h0000_0000;
    if (access && !pwrite) begin
      if (hit_rx) begin
        next_state.prdata = {24'h00_0000, state.rx_options};
      end else if (hit_stream) begin
        next_state.prdata = {24'h00_0000, state.stream_mode};
      end else if (hit_aux) begin
        next_state.prdata = {24'h00_0000, state.aux_options};
      end else if (hit_status) begin
        next_state.prdata = {31'h0000_0000, state.preset_seen};
      end
    end
    if (wr && hit_rx) begin
      next_state.rx_options = pwdata[7:0];
    end
    if (wr && hit_stream) begin
      next_state.stream_mode = pwdata[7:0] & `STREAM_WRITE_MASK;
    end
    if (wr && hit_aux) begin
      next_state.aux_options = pwdata[7:0];
    end
    // Preset acts after any same-cycle write so hardware wins
    if (analog_preset_cmd) begin
      next_state.aux_options[`BIT_AMPLITUDE_SEL] = preset_am;
      next_state.aux_options[`BIT_FIELD_DET]     = preset_field_det;
      next_state.preset_seen = 1'b1;
    end else if (wr && hit_status && pwdata[0]) begin
      next_state.preset_seen = 1'b0;
    end
    if (set_default_cmd) begin
      next_state.rx_options  = `RST_TYPEB_TYPEF_RX_OPTIONS;
      next_state.stream_mode = `RST_STREAM_MODE_DEFINITION;
      next_state.aux_options = `RST_AUXILIARY_OPTIONS;
    end

    // Decode from the values being loaded so outputs track registers in the same cycle
    rx_v = next_state.rx_options;
    sm_v = next_state.stream_mode;
    ax_v = next_state.aux_options;

    case (rx_v[7:6])
      2'b00: begin
        next_state.reply_delay       = `REPLY_DELAY_80;
        next_state.reply_delay_valid = 1'b1;
      end
      2'b01: begin
        next_state.reply_delay       = (bit_rate == nfc_opt_pkg::rate_fc128) ?
                                       `REPLY_DELAY_64 : `REPLY_DELAY_32;
        next_state.reply_delay_valid = 1'b1;
      end
      default: begin
        next_state.reply_delay       = 8'h00;
        next_state.reply_delay_valid = 1'b0;
      end
    endcase
    next_state.accept_no_sof  = rx_v[`BIT_NO_SOF];
    next_state.accept_no_eof  = rx_v[`BIT_NO_EOF];
    // Fast rates have one sub-carrier period per bit, so 11 and 12 etu blur
    next_state.eof_up_to_12   = rx_v[`BIT_EOF_WIDE] &&
                                (bit_rate != nfc_opt_pkg::rate_fc16_up);
    next_state.phase_tolerant = rx_v[`BIT_PHASE_TOL];
    next_state.preamble_len   = 7'(7'd48 + {rx_v[1:0], 4'b0000});

    case (sm_v[4:3])
      2'b00: begin
        next_state.report_pulses = 4'h1;
        next_state.pulses_valid  = bpsk_mode;
      end
      2'b01: begin
        next_state.report_pulses = 4'h2;
        next_state.pulses_valid  = 1'b1;
      end
      2'b10: begin
        next_state.report_pulses = 4'h4;
        next_state.pulses_valid  = 1'b1;
      end
      default: begin
        next_state.report_pulses = 4'h8;
        next_state.pulses_valid  = 1'b1;
      end
    endcase
    if (bpsk_mode) begin
      next_state.subcarrier_div_log2 = 3'(3'd4 - {1'b0, sm_v[6:5]});
      next_state.subcarrier_valid    = sm_v[6:5] != 2'b11;
    end else begin
      next_state.subcarrier_div_log2 = 3'(3'd6 - {1'b0, sm_v[6:5]});
      next_state.subcarrier_valid    = 1'b1;
    end
    next_state.tx_period_div_log2 = (sm_v[2:0] == 3'b111) ? 3'd0 :
                                    3'(3'd7 - sm_v[2:0]);
    next_state.tx_period_valid    = sm_v[2:0] != 3'b111;

    next_state.skip_crc = ax_v[`BIT_NO_CRC] || tx_reqa_cmd || tx_wupa_cmd ||
                          anticollision_frame;
    next_state.crc_to_fifo       = ax_v[`BIT_CRC_TO_FIFO];
    next_state.amplitude_mode    = ax_v[`BIT_AMPLITUDE_SEL];
    next_state.field_detector_on = ax_v[`BIT_FIELD_DET];
    // Float holds for every keyed protocol, not only transparent transmit
    next_state.driver_float      = ax_v[`BIT_DRIVER_FLOAT];
    next_state.rx_tolerant       = ax_v[`BIT_RX_TOL];
    next_state.field_on_count    = ax_v[1:0];
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state             <= '0;
      state.rx_options  <= `RST_TYPEB_TYPEF_RX_OPTIONS;
      state.stream_mode <= `RST_STREAM_MODE_DEFINITION;
      state.aux_options <= `RST_AUXILIARY_OPTIONS;
      state.reply_delay <= `REPLY_DELAY_80;
      state.reply_delay_valid   <= 1'b1;
      state.preamble_len        <= 7'd48;
      state.report_pulses       <= 4'h1;
      state.subcarrier_div_log2 <= 3'd6;
      state.subcarrier_valid    <= 1'b1;
      state.tx_period_div_log2  <= 3'd7;
      state.tx_period_valid     <= 1'b1;
      state.rx_tolerant         <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  assign pready              = state.pready;
  assign pslverr             = state.pslverr;
  assign prdata              = state.prdata;
  assign reply_delay         = state.reply_delay;
  assign reply_delay_valid   = state.reply_delay_valid;
  assign accept_no_sof       = state.accept_no_sof;
  assign accept_no_eof       = state.accept_no_eof;
  assign eof_up_to_12        = state.eof_up_to_12;
  assign phase_tolerant      = state.phase_tolerant;
  assign preamble_len        = state.preamble_len;
  assign report_pulses       = state.report_pulses;
  assign pulses_valid        = state.pulses_valid;
  assign subcarrier_div_log2 = state.subcarrier_div_log2;
  assign subcarrier_valid    = state.subcarrier_valid;
  assign tx_period_div_log2  = state.tx_period_div_log2;
  assign tx_period_valid     = state.tx_period_valid;
  assign skip_crc            = state.skip_crc;
  assign crc_to_fifo         = state.crc_to_fifo;
  assign amplitude_mode      = state.amplitude_mode;
  assign field_detector_on   = state.field_detector_on;
  assign driver_float        = state.driver_float;
  assign rx_tolerant         = state.rx_tolerant;
  assign field_on_count      = state.field_on_count;

  // Bus answer: one wait state, then pready for exactly one cycle
  sequence s_access_taken;
    psel && penable && !pready;
  endsequence

  sequence s_answer_pulse;
    pready ##1 !pready;
  endsequence

  sequence s_unmapped_access;
    s_access_taken ##0 !(hit_rx || hit_stream || hit_aux || hit_status);
  endsequence

  a_apb_one_wait: assert property (@(posedge clk) disable iff (srst)
    s_access_taken |=> s_answer_pulse)
    else $error("APB answer timing wrong");
  a_unmapped_error: assert property (@(posedge clk) disable iff (srst)
    s_unmapped_access |=> pready && pslverr && prdata == 32'h0000_0000)
    else $error("Unmapped access not refused");
  a_read_data_rx: assert property (@(posedge clk) disable iff (srst)
    s_access_taken ##0 (!pwrite && hit_rx) |=>
      !pslverr && prdata == {24'h00_0000, $past(state.rx_options)})
    else $error("Read data wrong for receive options");
  a_read_data_stream: assert property (@(posedge clk) disable iff (srst)
    s_access_taken ##0 (!pwrite && hit_stream) |=>
      !pslverr && prdata == {24'h00_0000, $past(state.stream_mode)})
    else $error("Read data wrong for stream register");
  a_read_data_aux: assert property (@(posedge clk) disable iff (srst)
    s_access_taken ##0 (!pwrite && hit_aux) |=>
      !pslverr && prdata == {24'h00_0000, $past(state.aux_options)})
    else $error("Read data wrong for auxiliary register");

  // Set default may load these bits too, so only a write without it is checked
  a_strobe_ignored: assert property (@(posedge clk) disable iff (srst)
    s_access_taken ##0 (pwrite && !pstrb[0] && hit_rx && !set_default_cmd) |=>
      $stable(state.rx_options))
    else $error("Write without byte strobe changed a register");
  a_status_clear: assert property (@(posedge clk) disable iff (srst)
    s_access_taken ##0 (pwrite && pstrb[0] && pwdata[0] && hit_status &&
                        !analog_preset_cmd) |=> !state.preset_seen)
    else $error("Status flag not cleared by write");
  a_status_set: assert property (@(posedge clk) disable iff (srst)
    analog_preset_cmd |=> state.preset_seen)
    else $error("Preset status flag not set");

  // Register loads
  a_default_load: assert property (@(posedge clk) disable iff (srst)
    set_default_cmd |=> state.aux_options == `RST_AUXILIARY_OPTIONS &&
                        state.rx_options == `RST_TYPEB_TYPEF_RX_OPTIONS &&
                        state.stream_mode == `RST_STREAM_MODE_DEFINITION)
    else $error("Set default did not load defaults");
  a_stream_bit7_zero: assert property (@(posedge clk) disable iff (srst)
    !state.stream_mode[7])
    else $error("Stream bit 7 set");
  a_preset_am: assert property (@(posedge clk) disable iff (srst)
    analog_preset_cmd && !set_default_cmd |=>
      state.aux_options[`BIT_AMPLITUDE_SEL] == $past(preset_am) &&
      amplitude_mode == $past(preset_am))
    else $error("Analog preset not applied");
  a_preset_field_det: assert property (@(posedge clk) disable iff (srst)
    analog_preset_cmd && !set_default_cmd |=>
      field_detector_on == $past(preset_field_det))
    else $error("Analog preset did not set field detector");

  // Decoded outputs track the registers in the same cycle; rate inputs lag by one
  a_reply_delay_map: assert property (@(posedge clk) disable iff (srst)
    state.rx_options[7:6] == 2'b00 |-> reply_delay == `REPLY_DELAY_80 && reply_delay_valid)
    else $error("Reply delay wrong for code 00");
  a_reply_delay_slow: assert property (@(posedge clk) disable iff (srst)
    ##1 (state.rx_options[7:6] == 2'b01 && $past(bit_rate) == 2'd0) |->
      reply_delay == `REPLY_DELAY_64)
    else $error("Reply delay wrong at lowest rate");
  a_reply_delay_fast: assert property (@(posedge clk) disable iff (srst)
    ##1 (state.rx_options[7:6] == 2'b01 && $past(bit_rate) != 2'd0) |->
      reply_delay == `REPLY_DELAY_32)
    else $error("Reply delay wrong above lowest rate");
  a_reply_unused: assert property (@(posedge clk) disable iff (srst)
    state.rx_options[7] |-> !reply_delay_valid)
    else $error("Unused reply delay code flagged valid");
  a_no_sof_flag: assert property (@(posedge clk) disable iff (srst)
    accept_no_sof == state.rx_options[`BIT_NO_SOF])
    else $error("No start of frame flag wrong");
  a_no_eof_flag: assert property (@(posedge clk) disable iff (srst)
    accept_no_eof == state.rx_options[`BIT_NO_EOF])
    else $error("No end of frame flag wrong");
  a_eof_window: assert property (@(posedge clk) disable iff (srst)
    ##1 eof_up_to_12 == (state.rx_options[`BIT_EOF_WIDE] && $past(bit_rate) != 2'd3))
    else $error("EOF window flag wrong");
  a_eof_fast_rate: assert property (@(posedge clk) disable iff (srst)
    bit_rate == 2'd3 |=> !eof_up_to_12)
    else $error("EOF widening active at fast rate");
  a_phase_tol: assert property (@(posedge clk) disable iff (srst)
    phase_tolerant == state.rx_options[`BIT_PHASE_TOL])
    else $error("Phase tolerance flag wrong");
  a_preamble_len: assert property (@(posedge clk) disable iff (srst)
    ##1 preamble_len == 7'd48 + 7'({state.rx_options[1:0], 4'b0000}))
    else $error("Preamble length mismatch");

  // Stream decode; the BPSK mode input lags by one cycle
  a_subcarrier_bpsk: assert property (@(posedge clk) disable iff (srst)
    ##1 subcarrier_valid == !($past(bpsk_mode) && state.stream_mode[6:5] == 2'b11))
    else $error("Sub-carrier validity wrong");
  a_pulses_map: assert property (@(posedge clk) disable iff (srst)
    report_pulses == 4'(4'h1 << state.stream_mode[4:3]))
    else $error("Report pulse count wrong");
  a_pulses_bpsk_only: assert property (@(posedge clk) disable iff (srst)
    ##1 (state.stream_mode[4:3] == 2'b00) |-> pulses_valid == $past(bpsk_mode))
    else $error("Single pulse valid outside BPSK");
  a_tx_period_unused: assert property (@(posedge clk) disable iff (srst)
    (state.stream_mode[2:0] == 3'b111) == !tx_period_valid)
    else $error("Tx period validity wrong");

  // Auxiliary bits; skip_crc also takes the short-frame commands
  a_crc_skip_bit: assert property (@(posedge clk) disable iff (srst)
    state.aux_options[`BIT_NO_CRC] |-> skip_crc)
    else $error("CRC not skipped with no-CRC bit");
  a_crc_auto_skip: assert property (@(posedge clk) disable iff (srst)
    tx_reqa_cmd || tx_wupa_cmd || anticollision_frame |=> skip_crc)
    else $error("CRC not skipped for short frame");
  a_crc_fifo_bit: assert property (@(posedge clk) disable iff (srst)
    crc_to_fifo == state.aux_options[`BIT_CRC_TO_FIFO])
    else $error("CRC to FIFO flag wrong");
  a_amplitude_bit: assert property (@(posedge clk) disable iff (srst)
    amplitude_mode == state.aux_options[`BIT_AMPLITUDE_SEL])
    else $error("Amplitude select flag wrong");
  a_field_det_bit: assert property (@(posedge clk) disable iff (srst)
    field_detector_on == state.aux_options[`BIT_FIELD_DET])
    else $error("Field detector flag wrong");
  a_driver_float_bit: assert property (@(posedge clk) disable iff (srst)
    driver_float == state.aux_options[`BIT_DRIVER_FLOAT])
    else $error("Driver float flag wrong");
  a_rx_tol_bit: assert property (@(posedge clk) disable iff (srst)
    rx_tolerant == state.aux_options[`BIT_RX_TOL])
    else $error("Receive tolerance flag wrong");
  a_field_on_count: assert property (@(posedge clk) disable iff (srst)
    field_on_count == state.aux_options[1:0])
    else $error("Field-on count wrong");

endmodule

// ### nfc_opt_defs.svh
`ifndef NFC_OPT_DEFS_SVH
`define NFC_OPT_DEFS_SVH

// Printed offsets are register indices; byte address is index times four
`define IDX_TYPEB_TYPEF_RX_OPTIONS  8'h07
`define IDX_STREAM_MODE_DEFINITION  8'h08
`define IDX_AUXILIARY_OPTIONS       8'h09
`define ADDR_TYPEB_TYPEF_RX_OPTIONS 12'h01C
`define ADDR_STREAM_MODE_DEFINITION 12'h020
`define ADDR_AUXILIARY_OPTIONS      12'h024
`define ADDR_EVENT_STATUS           12'h040

`define RST_TYPEB_TYPEF_RX_OPTIONS  8'h00
`define RST_STREAM_MODE_DEFINITION  8'h00
`define RST_AUXILIARY_OPTIONS       8'h04

// Field positions
`define BIT_NO_SOF          5
`define BIT_NO_EOF          4
`define BIT_EOF_WIDE        3
`define BIT_PHASE_TOL       2
`define BIT_NO_CRC          7
`define BIT_CRC_TO_FIFO     6
`define BIT_AMPLITUDE_SEL   5
`define BIT_FIELD_DET       4
`define BIT_DRIVER_FLOAT    3
`define BIT_RX_TOL          2
`define STREAM_WRITE_MASK   8'h7F

// Sub-carrier periods for reply delay
`define REPLY_DELAY_80      8'd80
`define REPLY_DELAY_64      8'd64
`define REPLY_DELAY_32      8'd32

`endif

// ### nfc_opt_pkg.sv
package nfc_opt_pkg;
  typedef enum logic [1:0] {
    rate_fc128,
    rate_fc64,
    rate_fc32,
    rate_fc16_up
  } bit_rate_type;

  typedef struct packed {
    logic [7:0] rx_options;
    logic [7:0] stream_mode;
    logic [7:0] aux_options;
    logic       pready;
    logic       pslverr;
    logic [31:0] prdata;
    logic [7:0] reply_delay;
    logic       reply_delay_valid;
    logic       accept_no_sof;
    logic       accept_no_eof;
    logic       eof_up_to_12;
    logic       phase_tolerant;
    logic [6:0] preamble_len;
    logic [3:0] report_pulses;
    logic       pulses_valid;
    logic [2:0] subcarrier_div_log2;
    logic       subcarrier_valid;
    logic [2:0] tx_period_div_log2;
    logic       tx_period_valid;
    logic       skip_crc;
    logic       crc_to_fifo;
    logic       amplitude_mode;
    logic       field_detector_on;
    logic       driver_float;
    logic       rx_tolerant;
    logic [1:0] field_on_count;
    logic       preset_seen;
  } state_type;
endpackage

// ### testbench.sv
`timescale 1ns/10ps
`include "nfc_opt_defs.svh"

module testbench;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [11:0] paddr;
  logic psel, penable, pwrite, pready, pslverr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb, report_pulses;
  logic set_default_cmd, analog_preset_cmd, preset_am, preset_field_det;
  logic tx_reqa_cmd, tx_wupa_cmd, anticollision_frame, bpsk_mode;
  logic [1:0] bit_rate, field_on_count;
  logic [7:0] reply_delay;
  logic [6:0] preamble_len;
  logic [2:0] subcarrier_div_log2, tx_period_div_log2;
  logic reply_delay_valid, accept_no_sof, accept_no_eof, eof_up_to_12, phase_tolerant;
  logic pulses_valid, subcarrier_valid, tx_period_valid, skip_crc, crc_to_fifo;
  logic amplitude_mode, field_detector_on, driver_float, rx_tolerant;
  logic [7:0] m_reg [3];
  logic m_status = 1'b0;
  int err_total = 0;
  int compares = 0;

  always #4 clk = ~clk;

  apb_host host_u (.clk, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .pready,
                   .pslverr, .prdata);

  nfc_framing_option_registers dut_u (.clk, .srst, .paddr, .psel, .penable, .pwrite,
    .pwdata, .pstrb, .pready, .pslverr, .prdata, .set_default_cmd, .analog_preset_cmd,
    .preset_am, .preset_field_det, .tx_reqa_cmd, .tx_wupa_cmd, .anticollision_frame,
    .bpsk_mode, .bit_rate, .reply_delay, .reply_delay_valid, .accept_no_sof,
    .accept_no_eof, .eof_up_to_12, .phase_tolerant, .preamble_len, .report_pulses,
    .pulses_valid, .subcarrier_div_log2, .subcarrier_valid, .tx_period_div_log2,
    .tx_period_valid, .skip_crc, .crc_to_fifo, .amplitude_mode, .field_detector_on,
    .driver_float, .rx_tolerant, .field_on_count);

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic load_defaults();
    m_reg[0] = `RST_TYPEB_TYPEF_RX_OPTIONS;
    m_reg[1] = `RST_STREAM_MODE_DEFINITION;
    m_reg[2] = `RST_AUXILIARY_OPTIONS;
  endtask

  task automatic check_outputs();
    logic [7:0] rx, st, ax;
    logic v;
    rx = m_reg[0];
    st = m_reg[1];
    ax = m_reg[2];
    check("reply", {reply_delay_valid, reply_delay & {8{reply_delay_valid}}}, rx[7:6] == 0 ?
      {1'b1, `REPLY_DELAY_80} : rx[7:6] == 1 ? {1'b1, bit_rate == 0 ? `REPLY_DELAY_64 :
      `REPLY_DELAY_32} : 9'h000);
    check("rx_flags", {accept_no_sof, accept_no_eof, eof_up_to_12, phase_tolerant},
      {rx[5], rx[4], rx[3] && bit_rate != 3, rx[2]});
    check("preamble", preamble_len, 7'(48 + 16 * rx[1:0]));
    v = !(bpsk_mode && st[6:5] == 3);
    check("subcarrier", {subcarrier_valid, subcarrier_div_log2 & {3{subcarrier_valid}}},
      {v, v ? 3'((bpsk_mode ? 4 : 6) - st[6:5]) : 3'h0});
    check("pulses", {pulses_valid, report_pulses}, {st[4:3] != 0 || bpsk_mode,
      4'(1 << st[4:3])});
    v = st[2:0] != 3'h7;
    check("tx_period", {tx_period_valid, tx_period_div_log2 & {3{tx_period_valid}}},
      {v, v ? 3'(7 - st[2:0]) : 3'h0});
    check("aux", {skip_crc, crc_to_fifo, amplitude_mode, field_detector_on, driver_float,
      rx_tolerant, field_on_count}, {ax[7] | tx_reqa_cmd | tx_wupa_cmd | anticollision_frame,
      ax[6:4], ax[3], ax[2:0]});
  endtask

  task automatic bus(input int idx, input logic w, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] rd;
    logic er, hung;
    host_u.xfer(idx == 4 ? `ADDR_EVENT_STATUS : idx == 3 ? 12'h030 : 12'(12'h01C + 4 * idx),
      w, d, s, rd, er, hung);
    if (hung) begin
      err_total++;
      print_verdict();
    end
    check("pslverr", er, idx == 3);
    if (!w) begin
      check("prdata", rd, idx == 4 ? {31'h0000_0000, m_status} :
        idx == 3 ? 32'h0000_0000 : {24'h00_0000, m_reg[idx]});
    end else if (idx < 3 && s[0]) begin
      m_reg[idx] = d[7:0] & (idx == 1 ? 8'h7F : 8'hFF);
    end else if (idx == 4 && s[0] && d[0]) begin
      m_status = 1'b0;
    end
  endtask

  task automatic settle();
    repeat (2) @(posedge clk);
    #1 check_outputs();
  endtask

  initial begin
    {set_default_cmd, analog_preset_cmd, preset_am, preset_field_det} = 4'h0;
    {tx_reqa_cmd, tx_wupa_cmd, anticollision_frame, bpsk_mode} = 4'h0;
    bit_rate = 2'b00;
    void'($urandom(32'h82ed_8040));
    load_defaults();
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    settle();
    for (int i = 0; i < 3; i++) bus(i, 1'b0, 32'h0000_0000, 4'h0);
    $display("test reset values done");
    for (int i = 0; i < 60; i++) begin
      bus($urandom_range(0, 4), 1'b1, $urandom, 4'($urandom_range(0, 15)));
      bit_rate <= 2'($urandom);
      bpsk_mode <= 1'($urandom);
      settle();
      for (int k = 0; k < 5; k++) bus(k, 1'b0, 32'h0000_0000, 4'hF);
    end
    $display("test random fields done");
    bus(2, 1'b1, 32'h0000_0008, 4'h1);
    for (int k = 0; k < 3; k++) begin
      {tx_reqa_cmd, tx_wupa_cmd, anticollision_frame} <= 3'(1 << k);
      settle();
    end
    {tx_reqa_cmd, tx_wupa_cmd, anticollision_frame} <= 3'h0;
    $display("test crc forcing done");
    @(posedge clk);
    {analog_preset_cmd, preset_am, preset_field_det} <= 3'h7;
    @(posedge clk);
    analog_preset_cmd <= 1'b0;
    m_reg[2][5:4] = 2'b11;
    m_status = 1'b1;
    settle();
    bus(4, 1'b0, 32'h0000_0000, 4'hF);
    bus(4, 1'b1, 32'h0000_0001, 4'h1);
    bus(4, 1'b0, 32'h0000_0000, 4'hF);
    bus(2, 1'b1, 32'h0000_0008, 4'h1);
    settle();
    $display("test analog preset done");
    for (int k = 0; k < 3; k++) bus(k, 1'b1, 32'hFFFF_FFFB, 4'hF);
    @(posedge clk);
    set_default_cmd <= 1'b1;
    @(posedge clk);
    set_default_cmd <= 1'b0;
    load_defaults();
    settle();
    for (int k = 0; k < 3; k++) bus(k, 1'b0, 32'h0000_0000, 4'hF);
    $display("test set default done");
    print_verdict();
  end
endmodule
